// file: design/latr_pkg.sv
// Package with register map, field layout and types of the lane alarm and offset trim bank
package latr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] LATR_ADDR_LANE_ALARM = 12'h2C4;
  localparam logic [11:0] LATR_ADDR_OFS_CORE0 = 12'h330;
  localparam logic [11:0] LATR_ADDR_OFS_CORE1 = 12'h332;
  localparam logic [11:0] LATR_ADDR_OFS_CORE2A = 12'h334;
  localparam logic [11:0] LATR_ADDR_SUMMARY = 12'h2C0;
  localparam logic [11:0] LATR_ADDR_CAL_CTRL = 12'h2D0;
  localparam logic [11:0] LATR_ADDR_CAL_STAT = 12'h2D2;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int LATR_LANES = 8;
  localparam int LATR_TRIM_W = 12;
  localparam int LATR_TRIMS = 3;
  localparam int LATR_SUMMARY_BIT = 5;
  localparam int LATR_OFFSET_CAL_ENABLE_BIT = 0;
  localparam int LATR_BACKGROUND_CAL_ENABLE_BIT = 1;
  localparam int LATR_BACKGROUND_OFFSET_CAL_ENABLE_BIT = 2;
  localparam int LATR_FOREGROUND_CAL_DONE_BIT = 0;
  localparam int LATR_OS_BUSY_BIT = 1;
  localparam int LATR_ACC_VIOL_BIT = 2;
  localparam logic [7:0] LATR_LANE_ALARM_RST = 8'hFF;
  localparam logic [15:0] LATR_SUMMARY_RST = 16'h0020;
  localparam logic [2:0] LATR_CAL_CTRL_RST = 3'h0;

  // Register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } latr_bus_s;

  // Calibration configuration bits
  typedef struct packed {
    logic bgos;
    logic bg;
    logic os;
  } latr_cal_s;

  typedef logic [LATR_TRIM_W-1:0] latr_trim_t;

  // Trim slot decode, used by write and read paths
  function automatic logic [1:0] latr_trim_slot(input logic [11:0] addr);
    logic [1:0] slot;
    slot = 2'h3;
    if (addr == LATR_ADDR_OFS_CORE0)
      slot = 2'h0;
    else if (addr == LATR_ADDR_OFS_CORE1)
      slot = 2'h1;
    else if (addr == LATR_ADDR_OFS_CORE2A)
      slot = 2'h2;
    return slot;
  endfunction

endpackage

// file: design/latr_regs.sv
// Lane FIFO alarm and offset trim register bank
`timescale 1ns/1ps
module latr_regs
  import latr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Lane FIFO events and lane activity
  input wire logic [LATR_LANES-1:0] lane_fifo_fault,
  input wire logic [LATR_LANES-1:0] lane_active,
  // Fuse memory
  input wire logic fuse_valid,
  input wire latr_trim_t fuse_trim [LATR_TRIMS],
  // Calibration engine
  input wire logic offset_cal_running,
  input wire logic foreground_cal_done,
  output latr_cal_s cal_cfg,
  output logic spare_offset_in_fg,
  // Converter core trims
  input wire logic core2_on_input_a,
  output latr_trim_t offset_trim_core0,
  output latr_trim_t offset_trim_core1,
  output latr_trim_t offset_trim_core2_input_a,
  output logic core2_input_a_trim_valid,
  // Summary alarm level
  output logic fifo_alarm_summary
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  latr_bus_s bus;
  logic [1:0] wr_slot;
  logic [1:0] rd_slot;
  logic wr_lane;
  logic wr_summary;
  logic wr_cal;
  logic trim_locked;

  // Request bundle and address decode
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign wr_slot = latr_trim_slot(bus.addr);
  assign rd_slot = latr_trim_slot(bus.addr);
  assign wr_lane = bus.wr && bus.addr == LATR_ADDR_LANE_ALARM;
  assign wr_summary = bus.wr && bus.addr == LATR_ADDR_SUMMARY;
  assign wr_cal = bus.wr && bus.addr == LATR_ADDR_CAL_CTRL;

  // ----------------------------------------------------------------
  // Calibration configuration
  // ----------------------------------------------------------------
  latr_cal_s cal_reg;
  logic fg_seen_reg;
  logic viol_reg;

  // Software-written calibration enables
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cal_reg <= LATR_CAL_CTRL_RST;
    else if (wr_cal)
      cal_reg <= '{bgos: bus.wdata[LATR_BACKGROUND_OFFSET_CAL_ENABLE_BIT], bg: bus.wdata[LATR_BACKGROUND_CAL_ENABLE_BIT],
                   os: bus.wdata[LATR_OFFSET_CAL_ENABLE_BIT]};
  end

  assign cal_cfg = cal_reg;

  // Spare cores get foreground offset cal when os and bg are on and bgos is off
  assign spare_offset_in_fg = cal_reg.os && cal_reg.bg && !cal_reg.bgos;

  // Foreground done latch, restarted by any configuration write unless done arrives in the same cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      fg_seen_reg <= 1'b0;
    else if (foreground_cal_done)
      fg_seen_reg <= 1'b1;
    else if (wr_cal)
      fg_seen_reg <= 1'b0;
  end

  // Trim access window: engine busy, awaiting foreground done, or full background
  always_comb
  begin
    trim_locked = offset_cal_running;
    if (cal_reg.os && (!cal_reg.bg || !cal_reg.bgos) && !fg_seen_reg)
      trim_locked = 1'b1;
    if (cal_reg.os && cal_reg.bg && cal_reg.bgos)
      trim_locked = 1'b1;
    if (!cal_reg.os)
      trim_locked = offset_cal_running;
  end

  // Sticky flag of a trim access in a locked window, write one clears
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      viol_reg <= 1'b0;
    else if ((bus.wr || bus.rd) && wr_slot != 2'h3 && trim_locked)
      viol_reg <= 1'b1;
    else if (bus.wr && bus.addr == LATR_ADDR_CAL_STAT && bus.wdata[LATR_ACC_VIOL_BIT])
      viol_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Lane alarms
  // ----------------------------------------------------------------
  logic [LATR_LANES-1:0] lane_alarm_reg;
  logic summary_reg;
  logic summary_clear;

  assign summary_clear = wr_summary && bus.wdata[LATR_SUMMARY_BIT];

  // Per-lane sticky bits, a fault in the clearing cycle wins
  genvar l;
  generate
    for (l = 0; l < LATR_LANES; l++)
    begin : g_lane
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          lane_alarm_reg[l] <= LATR_LANE_ALARM_RST[l];
        else if (lane_fifo_fault[l])
          lane_alarm_reg[l] <= 1'b1;
        else if (summary_clear)
          lane_alarm_reg[l] <= 1'b0;
        else if (wr_lane && bus.wdata[l])
          lane_alarm_reg[l] <= 1'b0;
      end
    end
  endgenerate

  // Summary bit from any active lane fault
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      summary_reg <= LATR_SUMMARY_RST[LATR_SUMMARY_BIT];
    else if (|(lane_fifo_fault & lane_active))
      summary_reg <= 1'b1;
    else if (summary_clear)
      summary_reg <= 1'b0;
  end

  assign fifo_alarm_summary = summary_reg;

  // ----------------------------------------------------------------
  // Offset trims
  // ----------------------------------------------------------------
  logic fuse_seen_reg;
  logic fuse_load;
  latr_trim_t trim_rd;
  latr_trim_t trim [LATR_TRIMS];

  // Single fuse copy after reset release
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      fuse_seen_reg <= 1'b0;
    else if (fuse_valid)
      fuse_seen_reg <= 1'b1;
  end

  assign fuse_load = fuse_valid && !fuse_seen_reg;

  // Reserved bits 15:12 are not stored
  latr_trim_mem u_trim_mem (
    .mclk(mclk),
    .rst_n(rst_n),
    .fuse_load(fuse_load),
    .fuse_trim(fuse_trim),
    .wr_en(bus.wr && wr_slot != 2'h3),
    .wr_slot(wr_slot),
    .wr_data(bus.wdata[LATR_TRIM_W-1:0]),
    .rd_slot(rd_slot),
    .rd_data(trim_rd),
    .trim(trim)
  );

  // Trim outputs to the converter cores
  assign offset_trim_core0 = trim[0];
  assign offset_trim_core1 = trim[1];
  assign offset_trim_core2_input_a = trim[2];
  assign core2_input_a_trim_valid = core2_on_input_a;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic rd_trim_reg;
  logic [15:0] rd_other_reg;

  // Non-trim read word registered; unmapped reads return zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_trim_reg <= 1'b0;
      rd_other_reg <= 16'h0000;
    end
    else
    begin
      rd_trim_reg <= bus.rd && rd_slot != 2'h3;
      rd_other_reg <= 16'h0000;
      if (bus.rd)
      begin
        unique case (bus.addr)
          LATR_ADDR_LANE_ALARM: rd_other_reg <= {8'h00, lane_alarm_reg};
          LATR_ADDR_SUMMARY: rd_other_reg <= 16'(summary_reg) << LATR_SUMMARY_BIT;
          LATR_ADDR_CAL_CTRL: rd_other_reg <= {13'h0000, cal_reg.bgos, cal_reg.bg, cal_reg.os};
          LATR_ADDR_CAL_STAT: rd_other_reg <= {13'h0000, viol_reg, offset_cal_running,
                                               fg_seen_reg};
          default: rd_other_reg <= 16'h0000;
        endcase
      end
    end
  end

  // Data stands only in the cycle after the read strobe
  assign reg_rdata = rd_trim_reg ? {4'h0, trim_rd} : rd_other_reg;

endmodule

// file: design/latr_trim_mem.sv
// Three-word offset trim store with fuse load and registered read data
`timescale 1ns/1ps
module latr_trim_mem
  import latr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Fuse load
  input wire logic fuse_load,
  input wire latr_trim_t fuse_trim [LATR_TRIMS],
  // Write port
  input wire logic wr_en,
  input wire logic [1:0] wr_slot,
  input wire latr_trim_t wr_data,
  // Read port
  input wire logic [1:0] rd_slot,
  output latr_trim_t rd_data,
  // Live values to the converter cores
  output latr_trim_t trim [LATR_TRIMS]
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  latr_trim_t mem_reg [LATR_TRIMS];
  latr_trim_t rd_reg;

  // One word per core; fuse load overrides a software write
  genvar g;
  generate
    for (g = 0; g < LATR_TRIMS; g++)
    begin : g_word
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          mem_reg[g] <= '0;
        else if (fuse_load)
          mem_reg[g] <= fuse_trim[g];
        else if (wr_en && wr_slot == 2'(g))
          mem_reg[g] <= wr_data;
      end
      assign trim[g] = mem_reg[g];
    end
  endgenerate

  // Registered read word
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rd_reg <= '0;
    else if (rd_slot < 2'(LATR_TRIMS))
      rd_reg <= mem_reg[rd_slot];
    else
      rd_reg <= '0;
  end

  assign rd_data = rd_reg;

endmodule

// file: dv/latr_regs_chk.sv
// Assertion checker for the lane alarm and offset trim bank
`timescale 1ns/1ps
module latr_regs_chk
  import latr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Lanes, fuse and calibration
  input wire logic [LATR_LANES-1:0] lane_fifo_fault,
  input wire logic [LATR_LANES-1:0] lane_active,
  input wire logic fuse_valid,
  input wire latr_cal_s cal_cfg,
  input wire logic spare_offset_in_fg,
  // Trims and summary
  input wire latr_trim_t offset_trim_core0,
  input wire latr_trim_t offset_trim_core1,
  input wire logic fifo_alarm_summary
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  wire lane_wr = reg_wr && reg_addr == LATR_ADDR_LANE_ALARM;
  wire lane_rd = reg_rd && reg_addr == LATR_ADDR_LANE_ALARM;
  wire sum_wr = reg_wr && reg_addr == LATR_ADDR_SUMMARY;
  wire ctl_wr = reg_wr && reg_addr == LATR_ADDR_CAL_CTRL;
  // Read data and trims
  chk_rd_idle: assert property
    (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside read slot");
  chk_trim_wr: assert property
    (reg_wr && reg_addr == LATR_ADDR_OFS_CORE0 && !fuse_valid
      |=> offset_trim_core0 == $past(reg_wdata[11:0])) else $error("core0 trim not written");
  chk_trim_rd: assert property
    (reg_rd && reg_addr == LATR_ADDR_OFS_CORE1
      |=> reg_rdata == {4'h0, $past(offset_trim_core1)}) else $error("core1 trim read wrong");
  // Lane alarms and summary
  chk_lane_clear: assert property
    (lane_wr && reg_wdata[7:0] == 8'hFF && lane_fifo_fault == 8'h00 ##1 lane_rd
      |=> reg_rdata[7:0] == 8'h00) else $error("lane alarms not cleared");
  chk_lane_stick: assert property
    (lane_fifo_fault == 8'hFF ##1 lane_rd |=> reg_rdata[7:0] == 8'hFF)
    else $error("lane alarm lost while fault persists");
  chk_sum_set: assert property
    (|(lane_fifo_fault & lane_active) && !sum_wr |=> fifo_alarm_summary)
    else $error("summary alarm not set");
  chk_sum_hold: assert property
    (fifo_alarm_summary && !sum_wr |=> fifo_alarm_summary) else $error("summary alarm dropped");
  chk_sum_clear: assert property
    (sum_wr && reg_wdata[LATR_SUMMARY_BIT] && lane_fifo_fault == 8'h00
      |=> !fifo_alarm_summary) else $error("summary alarm not cleared");
  // Calibration configuration
  chk_cfg_load: assert property
    (ctl_wr |=> cal_cfg == $past(reg_wdata[2:0])) else $error("cal config not loaded");
  chk_spare_fg: assert property
    (ctl_wr && reg_wdata[2:0] == 3'h3 ##1 !ctl_wr |=> spare_offset_in_fg)
    else $error("spare offset step not enabled");
  // Main scenarios seen
  cov_lane_wr: cover property (lane_wr);
  cov_sum_wr: cover property (sum_wr);
  cov_spare: cover property (spare_offset_in_fg);
endmodule

bind latr_regs latr_regs_chk u_chk (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .lane_fifo_fault, .lane_active, .fuse_valid, .cal_cfg, .spare_offset_in_fg,
  .offset_trim_core0, .offset_trim_core1, .fifo_alarm_summary);

// file: dv/latr_regs_tb_top.sv
// Self-checking bench for the lane alarm and offset trim bank
`timescale 1ns/1ps
module latr_regs_tb_top
  import latr_pkg::*;
;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0] lane_fifo_fault = 8'h00;
  logic [7:0] lane_active = 8'h00;
  logic fuse_valid = 1'b0;
  latr_trim_t fuse_trim [LATR_TRIMS];
  logic offset_cal_running = 1'b0;
  logic foreground_cal_done = 1'b0;
  logic core2_on_input_a = 1'b0;
  latr_cal_s cal_cfg;
  logic spare_offset_in_fg;
  logic core2_input_a_trim_valid;
  logic fifo_alarm_summary;
  latr_trim_t offset_trim_core0;
  latr_trim_t offset_trim_core1;
  latr_trim_t offset_trim_core2_input_a;
  logic [11:0] ta [3] = '{LATR_ADDR_OFS_CORE0, LATR_ADDR_OFS_CORE1, LATR_ADDR_OFS_CORE2A};
  logic [15:0] d;
  int bad_count = 0;
  int samples_checked = 0;
  int k;

  latr_regs u_dut (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .lane_fifo_fault, .lane_active, .fuse_valid, .fuse_trim, .offset_cal_running,
    .foreground_cal_done, .cal_cfg, .spare_offset_in_fg, .core2_on_input_a,
    .offset_trim_core0, .offset_trim_core1, .offset_trim_core2_input_a,
    .core2_input_a_trim_valid, .fifo_alarm_summary);

  // Clock of 50 ns
  always #25 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Trim as seen in its register
  function automatic logic [15:0] exp_trim(input logic [15:0] v);
    return {4'h0, v[11:0]};
  endfunction

  function automatic logic [15:0] port_trim(input int i);
    return {4'h0, i == 0 ? offset_trim_core0 : i == 1 ? offset_trim_core1
      : offset_trim_core2_input_a};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // Idle edge so a following write never re-raises the strobe in this step
    @(posedge mclk);
  endtask

  // Read, compare in the data slot, realign on the clock
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    @(posedge mclk);
  endtask

  // Trim access under one calibration setting, then status read
  task automatic lock_case(input logic [15:0] ctl, input logic run, input logic fg,
    input logic [15:0] e);
    foreground_cal_done <= fg;
    offset_cal_running <= run;
    wr(LATR_ADDR_CAL_CTRL, ctl);
    @(posedge mclk);
    wr(LATR_ADDR_OFS_CORE1, 16'h0ABC);
    rd(LATR_ADDR_CAL_STAT, e);
    wr(LATR_ADDR_CAL_STAT, 16'h0004);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hFD24));
    for (k = 0; k < 3; k++)
      fuse_trim[k] = 12'($urandom);
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(LATR_ADDR_LANE_ALARM, 16'h00FF);
    rd(LATR_ADDR_SUMMARY, LATR_SUMMARY_RST);
    fuse_valid <= 1'b1;
    @(posedge mclk);
    fuse_valid <= 1'b0;
    for (k = 0; k < 3; k++)
      rd(ta[k], exp_trim(16'(fuse_trim[k])));
    // Trim writes: corner values then random, reserved bits kept zero
    for (k = 0; k < 12; k++)
    begin
      d = k < 3 ? 16'h0FFF : k < 6 ? 16'h0000 : {4'h0, 12'($urandom)};
      core2_on_input_a <= 1'($urandom);
      wr(ta[k % 3], d);
      wr(12'h3FE, 16'hFFFF);
      rd(ta[k % 3], exp_trim(d));
      #1;
      chk(port_trim(k % 3), exp_trim(d));
      chk(16'(core2_input_a_trim_valid), 16'(core2_on_input_a));
      @(posedge mclk);
    end
    wr(LATR_ADDR_LANE_ALARM, 16'h00FF);
    rd(LATR_ADDR_LANE_ALARM, 16'h0000);
    // One lane at a time, with random lane activity
    for (k = 0; k < 8; k++)
    begin
      wr(LATR_ADDR_SUMMARY, 16'h0020);
      lane_active <= 8'($urandom);
      lane_fifo_fault <= 8'h01 << k;
      @(posedge mclk);
      lane_fifo_fault <= 8'h00;
      #1;
      chk(16'(fifo_alarm_summary), 16'(lane_active[k]));
      @(posedge mclk);
      wr(LATR_ADDR_LANE_ALARM, {8'h00, ~(8'h01 << k)});
      rd(LATR_ADDR_LANE_ALARM, 16'h0001 << k);
      wr(LATR_ADDR_LANE_ALARM, 16'h0001 << k);
      rd(LATR_ADDR_LANE_ALARM, 16'h0000);
    end
    // Clear while faults persist, then summary clear of all lanes
    lane_fifo_fault <= 8'hFF;
    @(posedge mclk);
    wr(LATR_ADDR_LANE_ALARM, 16'h00FF);
    rd(LATR_ADDR_LANE_ALARM, 16'h00FF);
    lane_fifo_fault <= 8'h00;
    @(posedge mclk);
    wr(LATR_ADDR_SUMMARY, 16'h0020);
    rd(LATR_ADDR_LANE_ALARM, 16'h0000);
    chk(16'(fifo_alarm_summary), 16'h0000);
    // Calibration settings and trim access status
    lock_case(16'h0001, 1'b0, 1'b0, 16'h0004);
    lock_case(16'h0001, 1'b0, 1'b1, 16'h0001);
    lock_case(16'h0007, 1'b0, 1'b1, 16'h0005);
    lock_case(16'h0000, 1'b1, 1'b0, 16'h0006);
    lock_case(16'h0002, 1'b0, 1'b0, 16'h0000);
    lock_case(16'h0003, 1'b0, 1'b1, 16'h0001);
    for (k = 0; k < 4 && spare_offset_in_fg !== 1'b1; k++)
      @(posedge mclk);
    chk(16'(spare_offset_in_fg), 16'h0001);
    final_report();
  end
endmodule
